// *** sli_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sli_ctrl_model (
  input wire logic [2:0] cmd_i,
  output logic lock_request_o,
  output logic release_ch1_o,
  output logic release_ch2_o
);
  // Channels may disagree: a broken pair is legal stimulus
  assign {lock_request_o, release_ch1_o, release_ch2_o} = cmd_i;
endmodule // sli_ctrl_model
`default_nettype wire

// *** sli_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sli_regs.vh"
module sli_props (
  input wire clk_i,
  input wire rst_b_i,
  input wire actuator_valid_i,
  input wire lock_request_i,
  input wire release_ch1_i,
  input wire release_ch2_i,
  input wire [1:0] status_lamp_o,
  input wire [1:0] lock_lamp_o,
  input wire [1:0] fault_hint_lamp_o,
  input wire [1:0] safety_output_pair_o,
  input wire teach_fail_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_on;
    safety_output_pair_o == 2'b11;
  endsequence
  property p_pair; safety_output_pair_o[0] == safety_output_pair_o[1]; endproperty
  a_pair: assert property (p_pair) else $error("pair bits differ");
  property p_no_act; !actuator_valid_i |=> safety_output_pair_o == 2'b00; endproperty
  a_no_act: assert property (p_no_act) else $error("outputs on without actuator");
  property p_rel_bad; !(release_ch1_i && release_ch2_i) |=> safety_output_pair_o == 2'b00; endproperty
  a_rel_bad: assert property (p_rel_bad) else $error("outputs on with bad channels");
  property p_on_lamps; s_on |-> status_lamp_o == `SLI_LAMP_GRN && lock_lamp_o == `SLI_LAMP_GRN
    && fault_hint_lamp_o == `SLI_LAMP_OFF; endproperty
  a_on_lamps: assert property (p_on_lamps) else $error("lamps wrong with outputs on");
  property p_lock_dark; s_on ##1 !lock_request_i |=> lock_lamp_o == `SLI_LAMP_OFF; endproperty
  a_lock_dark: assert property (p_lock_dark) else $error("lock lamp lit without request");
  property p_drop; s_on ##1 !actuator_valid_i |=> status_lamp_o == `SLI_LAMP_RED; endproperty
  a_drop: assert property (p_drop) else $error("status not red after loss");
  property p_fail_out; teach_fail_o |-> safety_output_pair_o == 2'b00; endproperty
  a_fail_out: assert property (p_fail_out) else $error("outputs on in failure");
  property p_fail_hold; teach_fail_o |=> teach_fail_o && lock_lamp_o == `SLI_LAMP_OFF; endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failure left or lock lit");
endmodule // sli_props
bind sli_status_lamps sli_props u_props (.clk_i, .rst_b_i, .actuator_valid_i, .lock_request_i,
  .release_ch1_i, .release_ch2_i, .status_lamp_o, .lock_lamp_o, .fault_hint_lamp_o,
  .safety_output_pair_o, .teach_fail_o);
`default_nettype wire

// *** sli_regs.vh ***
`ifndef SLI_REGS_VH
`define SLI_REGS_VH
// Lamp colour codes {red, green}; yellow is both bits lit
`define SLI_LAMP_OFF 2'b00
`define SLI_LAMP_GRN 2'b01
`define SLI_LAMP_RED 2'b10
`define SLI_LAMP_YEL 2'b11
// Clock and blink timing
`define SLI_CLK_HZ 10000000
`define SLI_BLINK_4HZ_HALF_CYC (`SLI_CLK_HZ / 8)
`define SLI_DIV_W 24
// Teach-in restart window, minutes
`define SLI_TEACH_WIN_MIN 5
`define SLI_TEACH_WIN_CYC (32'd60 * `SLI_TEACH_WIN_MIN * `SLI_CLK_HZ)
// Self-test duration, cycles
`define SLI_SELFTEST_CYC 20000000
`endif

// *** sli_status_lamps.v ***
`timescale 1ns/100ps
`default_nettype none
`include "sli_regs.vh"
module sli_status_lamps #(
  parameter SELFTEST_CYC = `SLI_SELFTEST_CYC,
  parameter TEACH_WIN_CYC = `SLI_TEACH_WIN_CYC,
  parameter HALF_4HZ_CYC = `SLI_BLINK_4HZ_HALF_CYC,
  parameter UNLOCKED_OUTPUTS_ON = 1'b0
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire actuator_valid_i,
  input wire actuator_taught_i,
  input wire teach_busy_i,
  input wire teach_done_i,
  input wire lock_request_i,
  input wire locked_i,
  input wire release_ch1_i,
  input wire release_ch2_i,
  output reg [1:0] status_lamp_o,
  output reg [1:0] lock_lamp_o,
  output reg [1:0] fault_hint_lamp_o,
  output reg [1:0] safety_output_pair_o,
  output reg teach_fail_o
);
  localparam ST_SELFTEST = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_TEACH = 3'h2;
  localparam ST_TAUGHT = 3'h3;
  localparam ST_FAIL_TIME = 3'h4;
  localparam ST_FAIL_GONE = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  // Wide timer: five minutes at full clock rate
  reg [31:0] timer_reg;
  reg [31:0] timer_next;

  reg [`SLI_DIV_W-1:0] div_reg;
  reg [`SLI_DIV_W-1:0] div_next;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;

  reg [1:0] status_next;
  reg [1:0] lock_next;
  reg [1:0] hint_next;
  reg [1:0] run_lock;
  reg outs_next;
  reg fail_next;

  wire div_wrap;
  wire blink4;
  wire blink2;
  wire blink1;
  wire chans_ok;
  wire selftest_end;
  wire window_end;

  assign div_wrap = (div_reg >= HALF_4HZ_CYC - 1);

  always @* begin
    div_next = div_reg + {{(`SLI_DIV_W-1){1'b0}}, 1'b1};
    phase_next = phase_reg;
    if (div_wrap) begin
      div_next = {`SLI_DIV_W{1'b0}};
      phase_next = phase_reg + 3'h1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg <= {`SLI_DIV_W{1'b0}};
    end else begin
      div_reg <= div_next;
    end
  end

  // One phase word, so equal rates stay in step
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign blink4 = phase_reg[0];
  assign blink2 = phase_reg[1];
  assign blink1 = phase_reg[2];
  assign chans_ok = release_ch1_i & release_ch2_i;
  assign selftest_end = (timer_reg >= SELFTEST_CYC - 1);
  assign window_end = (timer_reg >= TEACH_WIN_CYC - 1);

  // Timer runs only in self-test and taught window
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg + 32'h1;
    case (state_reg)
      ST_SELFTEST: begin
        if (selftest_end) begin
          state_next = ST_RUN;
          timer_next = 32'h0;
        end
      end
      ST_RUN: begin
        timer_next = 32'h0;
        if (teach_busy_i) begin
          state_next = ST_TEACH;
        end
      end
      ST_TEACH: begin
        timer_next = 32'h0;
        if (!actuator_valid_i) begin
          state_next = ST_FAIL_GONE;
        end else if (teach_done_i) begin
          state_next = ST_TAUGHT;
        end
      end
      ST_TAUGHT: begin
        if (window_end) begin
          state_next = ST_FAIL_TIME;
          timer_next = 32'h0;
        end
      end
      // Fail states end only at reset
      ST_FAIL_TIME: begin
        timer_next = 32'h0;
      end
      ST_FAIL_GONE: begin
        timer_next = 32'h0;
      end
      default: begin
        state_next = ST_SELFTEST;
        timer_next = 32'h0;
      end
    endcase
  end

  always @* begin
    run_lock = `SLI_LAMP_OFF;
    if (!lock_request_i) begin
      run_lock = `SLI_LAMP_OFF;
    end else if (locked_i) begin
      run_lock = `SLI_LAMP_GRN;
    end else begin
      run_lock = blink1 ? `SLI_LAMP_GRN : `SLI_LAMP_OFF;
    end
  end

  // Defaults status red, lock and hint dark, outputs off, so any gap fails safe
  always @* begin
    status_next = `SLI_LAMP_RED;
    lock_next = `SLI_LAMP_OFF;
    hint_next = `SLI_LAMP_OFF;
    outs_next = 1'b0;
    case (state_reg)
      ST_SELFTEST: begin
        status_next = blink2 ? `SLI_LAMP_GRN : `SLI_LAMP_RED;
        lock_next = blink2 ? `SLI_LAMP_GRN : `SLI_LAMP_YEL;
        hint_next = blink2 ? `SLI_LAMP_YEL : `SLI_LAMP_RED;
      end
      ST_TEACH: begin
        status_next = blink4 ? `SLI_LAMP_GRN : `SLI_LAMP_OFF;
        hint_next = blink4 ? `SLI_LAMP_YEL : `SLI_LAMP_RED;
      end
      ST_TAUGHT: begin
        status_next = blink4 ? `SLI_LAMP_GRN : `SLI_LAMP_OFF;
        hint_next = blink4 ? `SLI_LAMP_YEL : `SLI_LAMP_OFF;
      end
      ST_FAIL_TIME: begin
        status_next = blink4 ? `SLI_LAMP_GRN : `SLI_LAMP_RED;
        hint_next = blink4 ? `SLI_LAMP_RED : `SLI_LAMP_OFF;
      end
      ST_FAIL_GONE: begin
        status_next = blink4 ? `SLI_LAMP_GRN : `SLI_LAMP_RED;
        hint_next = `SLI_LAMP_RED;
      end
      default: begin
        lock_next = run_lock;
        if (!actuator_valid_i) begin
          status_next = `SLI_LAMP_RED;
          if (!actuator_taught_i) begin
            hint_next = blink4 ? `SLI_LAMP_YEL : `SLI_LAMP_RED;
          end else if (!chans_ok) begin
            hint_next = `SLI_LAMP_YEL;
          end
        end else if (!chans_ok) begin
          hint_next = `SLI_LAMP_YEL;
          status_next = blink1 ? `SLI_LAMP_GRN : `SLI_LAMP_OFF;
        end else if (lock_request_i && locked_i) begin
          status_next = `SLI_LAMP_GRN;
          outs_next = 1'b1;
        end else if (!lock_request_i && !locked_i && UNLOCKED_OUTPUTS_ON) begin
          status_next = `SLI_LAMP_GRN;
          outs_next = 1'b1;
        end else begin
          status_next = blink1 ? `SLI_LAMP_GRN : `SLI_LAMP_OFF;
        end
      end
    endcase
  end

  // Flag follows the state being entered
  always @* begin
    fail_next = 1'b0;
    if ((state_next == ST_FAIL_TIME) || (state_next == ST_FAIL_GONE)) begin
      fail_next = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_SELFTEST;
      timer_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_lamp_o <= `SLI_LAMP_OFF;
    end else begin
      status_lamp_o <= status_next;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_lamp_o <= `SLI_LAMP_OFF;
    end else begin
      lock_lamp_o <= lock_next;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_hint_lamp_o <= `SLI_LAMP_OFF;
    end else begin
      fault_hint_lamp_o <= hint_next;
    end
  end

  // Both bits from one decode, so the pair never splits
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      safety_output_pair_o <= 2'b00;
    end else begin
      safety_output_pair_o <= {outs_next, outs_next};
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      teach_fail_o <= 1'b0;
    end else begin
      teach_fail_o <= fail_next;
    end
  end
endmodule // sli_status_lamps
`default_nettype wire

// *** test_safety_lock_status_indicator.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sli_regs.vh"
module test_safety_lock_status_indicator;
  logic clk_i = 0, rst_b_i = 0, act = 0, taught = 1, busy = 0, done = 0, locked = 0;
  logic [2:0] cmd = 0;
  wire lreq, ch1, ch2, tfail;
  wire [1:0] st, lk, hint, pair;
  int miscompares = 0, checked = 0, cyc = 0;
  initial forever #50 clk_i = ~clk_i;
  sli_ctrl_model ctl_u (.cmd_i(cmd), .lock_request_o(lreq), .release_ch1_o(ch1), .release_ch2_o(ch2));
  sli_status_lamps #(.SELFTEST_CYC(100), .TEACH_WIN_CYC(200), .HALF_4HZ_CYC(4)) dut_u (.clk_i, .rst_b_i,
    .actuator_valid_i(act), .actuator_taught_i(taught), .teach_busy_i(busy), .teach_done_i(done),
    .lock_request_i(lreq), .locked_i(locked), .release_ch1_i(ch1), .release_ch2_i(ch2), .status_lamp_o(st),
    .lock_lamp_o(lk), .fault_hint_lamp_o(hint), .safety_output_pair_o(pair), .teach_fail_o(tfail));
  task automatic chk2(string n, logic [1:0] e, logic [1:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk2(n, {1'b0, e}, {1'b0, g});
  endtask
  function automatic logic [1:0] exp_pair(logic a, logic l, logic [2:0] c);
    return (a && l && c == 3'h7) ? 2'h3 : 2'h0;
  endfunction
  task automatic pwr(logic t);
    rst_b_i = 0;
    taught = t;
    done = 0;
    repeat (8) @(negedge clk_i);
    rst_b_i = 1;
    repeat (100) begin
      @(negedge clk_i);
      chk2("selftest pair", 2'h0, pair);
    end
    repeat (10) @(negedge clk_i);
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h9f5dcade));
    pwr(1);
    repeat (300) begin
      {act, locked, cmd} = 5'($urandom);
      if ($urandom % 4 == 0) {act, locked, cmd} = 5'h1f;
      @(negedge clk_i);
      chk2("pair", exp_pair(act, locked, cmd), pair);
      if (!cmd[2]) chk2("lock dark", `SLI_LAMP_OFF, lk);
      if (!act) chk2("status red", `SLI_LAMP_RED, st);
      if (act && cmd[1:0] != 2'h3) chk2("hint", `SLI_LAMP_YEL, hint);
      if (act && cmd[1:0] != 2'h3) chk1("blink status red bit", 1'b0, st[1]);
      if (act && locked && cmd[2]) chk2("lock green", `SLI_LAMP_GRN, lk);
    end
    $display("test normal done");
    {act, locked, cmd} = 5'h0;
    pwr(0);
    chk2("factory status", `SLI_LAMP_RED, st);
    {act, busy} = 2'h3;
    repeat (2) @(negedge clk_i);
    chk2("teach lock", `SLI_LAMP_OFF, lk);
    {busy, done} = 2'h1;
    repeat (190) @(negedge clk_i);
    chk2("taught pair", 2'h0, pair);
    repeat (20) @(negedge clk_i);
    chk1("window fail", 1, tfail);
    $display("test window done");
    act = 0;
    pwr(0);
    {act, busy} = 2'h3;
    repeat (2) @(negedge clk_i);
    act = 0;
    repeat (2) @(negedge clk_i);
    chk1("early fail", 1, tfail);
    chk2("early hint", `SLI_LAMP_RED, hint);
    $display("test removal done");
    final_report();
  end
endmodule // test_safety_lock_status_indicator
`default_nettype wire
